// ---- rtl/scs_defs.vh ----
`ifndef SCS_DEFS_VH
`define SCS_DEFS_VH
// Register reset values.
`define SCS_SELECT_RST 8'hff
`define SCS_SERIAL_RST 8'hff
`define SCS_DIAG_RST 8'hff
// Command codes: upper six bits of the control byte.
`define SCS_CMD_WR_STATE 6'h26
`define SCS_CMD_RD_STATE 6'h25
`define SCS_CMD_WR_SELECT 6'h2a
`define SCS_CMD_RD_SELECT 6'h29
`define SCS_CMD_READ_DIAGNOSIS_CMD 6'h20
// Address bits 7:6 of the control byte must read 2'b10.
`define SCS_ADDR_CODE 2'h2
// Frame length in serial clock falling edges.
`define SCS_FRAME_BITS 5'h10
// Channel status codes.
`define SCS_ST_OK 2'h3
`define SCS_ST_OVERLOAD 2'h2
`define SCS_ST_OPEN 2'h1
`define SCS_ST_SHORT_GND 2'h0
`endif

// ---- rtl/scs_switch_ctrl.v ----
`include "scs_defs.vh"

module scs_switch_ctrl (
  input wire clk,
  input wire reset,
  input wire reset_n_pin,
  input wire cs_n,
  input wire sclk,
  input wire si,
  output reg so_out,
  output reg so_oe_n,
  input wire [5:0] parallel_input_pin,
  input wire input_polarity_pin,
  input wire [5:0] ch_overload,
  input wire [5:0] ch_open_load,
  input wire [5:0] ch_short_gnd,
  input wire [5:0] ch_overtemp,
  output reg [5:0] power_output,
  output reg fault_n
);
  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisation.
  // Every pin, including the serial clock, is sampled by clk. The link
  // therefore needs several clk periods per serial clock half period, and
  // the fault inputs are seen a few clocks late. That is acceptable for
  // latched diagnosis.
  wire [3:0] ctl_s;
  wire [5:0] par_s;
  wire pol_s;
  wire [23:0] flt_s;

  // The reset values match the idle pins, so no false edge follows reset.
  scs_sync #(.W(4), .INIT(4'hc)) u_ctl (
    .clk(clk),
    .reset(reset),
    .d({reset_n_pin, cs_n, sclk, si}),
    .q(ctl_s)
  );
  scs_sync #(.W(7), .INIT(7'h7f)) u_par (
    .clk(clk),
    .reset(reset),
    .d({input_polarity_pin, parallel_input_pin}),
    .q({pol_s, par_s})
  );
  scs_sync #(.W(24), .INIT(24'h000000)) u_flt (
    .clk(clk),
    .reset(reset),
    .d({ch_overtemp, ch_short_gnd, ch_open_load, ch_overload}),
    .q(flt_s)
  );

  wire rst_pin_n = ctl_s[3];
  wire csn = ctl_s[2];
  wire sck = ctl_s[1];
  wire sdi = ctl_s[0];
  wire [5:0] ovl = flt_s[5:0];
  wire [5:0] opl = flt_s[11:6];
  wire [5:0] short_to_ground = flt_s[17:12];
  wire [5:0] otp = flt_s[23:18];

  // Edges of the synchronised chip select and serial clock. Clock edges
  // count only while chip select is low, so idle toggling is ignored.
  reg csn_d_r;
  reg sck_d_r;
  always @(posedge clk) begin
    if (reset) begin
      csn_d_r <= 1'b1;
      sck_d_r <= 1'b0;
    end else begin
      csn_d_r <= csn;
      sck_d_r <= sck;
    end
  end
  wire cs_fall = csn_d_r & ~csn;
  wire cs_rise = ~csn_d_r & csn;
  wire sck_rise = ~sck_d_r & sck & ~csn;
  wire sck_fall = sck_d_r & ~sck & ~csn;

  ////////////////////////////////////////////////////////////////////////////
  // Latched per-channel fault status.
  // Each channel keeps the worst fault seen since the last clearing frame.
  // Short to ground beats open load, which beats overload or overtemp.
  // A clear restarts from the no-fault code and still applies the faults
  // of that cycle, so an event in the clearing cycle is never lost.
  wire [11:0] diag_st;
  reg ot_n_r;
  wire clear_req;
  genvar k;
  generate
    for (k = 0; k < 6; k = k + 1) begin : g_diag
      reg [1:0] st_r;
      reg [1:0] base;
      reg [1:0] st_nxt;
      always @* begin
        base = clear_req ? `SCS_ST_OK : st_r;
        st_nxt = base;
        if (short_to_ground[k]) begin
          st_nxt = `SCS_ST_SHORT_GND;
        end else if (opl[k] && base != `SCS_ST_SHORT_GND) begin
          st_nxt = `SCS_ST_OPEN;
        end else if ((ovl[k] || otp[k]) && base == `SCS_ST_OK) begin
          st_nxt = `SCS_ST_OVERLOAD;
        end
      end
      always @(posedge clk) begin
        if (reset || !rst_pin_n) begin
          st_r <= `SCS_ST_OK;
        end else begin
          st_r <= st_nxt;
        end
      end
      assign diag_st[2*k +: 2] = st_r;
    end
  endgenerate

  // Overtemp is one latched flag over all six sensors; set beats clear.
  always @(posedge clk) begin
    if (reset || !rst_pin_n) begin
      ot_n_r <= 1'b1;
    end else if (|otp) begin
      ot_n_r <= 1'b0;
    end else if (clear_req) begin
      ot_n_r <= 1'b1;
    end
  end
  wire common_fault_n = &diag_st & ot_n_r;

  ////////////////////////////////////////////////////////////////////////////
  // Serial frame engine.
  // Bits are taken on the synchronised falling edge of the serial clock
  // and counted; the count saturates so that an over-long frame can never
  // wrap back to sixteen. The device decides after two bits whether it is
  // addressed and only then drives the serial output. The second returned
  // byte is chosen as soon as the control byte is complete, which leaves
  // many clk periods before the next rising serial clock edge needs it.
  reg [15:0] shift_r;
  reg [4:0] cnt_r;
  reg addressed_r;
  reg [7:0] tx_r;
  reg [7:0] select_r;
  reg [7:0] state_r;
  // Control byte as it stands once all sixteen bits are in.
  wire [5:0] cmd = shift_r[15:10];
  wire read_diagnosis_cmd = (cmd == `SCS_CMD_READ_DIAGNOSIS_CMD);
  wire write_serial_state_cmd = (cmd == `SCS_CMD_WR_STATE);
  wire write_select_cmd = (cmd == `SCS_CMD_WR_SELECT);
  wire good_len = (cnt_r == `SCS_FRAME_BITS);
  // A frame is acted on only if it was addressed and exactly 16 long.
  wire frame_ok = cs_rise && addressed_r && good_len;
  wire [7:0] hi_byte = {2'h3, common_fault_n, ot_n_r,
                        diag_st[11:8]};
  wire [7:0] lo_byte = diag_st[7:0];

  // Second returned byte, picked when the eighth bit is taken. At that
  // edge bits 7 to 1 of the control byte sit in shift_r[6:0] and the last
  // bit is only arriving, so shift_r[6:1] holds the six code bits.
  wire [5:0] ctl_code = shift_r[6:1];
  reg [7:0] second_nxt;
  always @* begin
    case (ctl_code)
      `SCS_CMD_RD_STATE: begin
        second_nxt = {state_r[7:2], 2'h3};
      end
      `SCS_CMD_RD_SELECT: begin
        second_nxt = {select_r[7:2], 2'h3};
      end
      default: begin
        second_nxt = lo_byte;
      end
    endcase
  end

  // Serial output bit for the current pulse. The first byte comes from the
  // live status, so a fault seen during the frame is not hidden.
  wire [2:0] bit_pos = 3'h7 - cnt_r[2:0];
  wire so_bit = (cnt_r < 5'h08) ? hi_byte[bit_pos] : tx_r[bit_pos];
  wire drive_ok = addressed_r ||
                  (cnt_r == 5'h02 && shift_r[1:0] == `SCS_ADDR_CODE);

  assign clear_req = frame_ok && read_diagnosis_cmd;

  always @(posedge clk) begin
    if (reset || !rst_pin_n) begin
      shift_r <= 16'h0000;
      cnt_r <= 5'h00;
      addressed_r <= 1'b0;
      tx_r <= 8'hff;
      so_out <= 1'b0;
      so_oe_n <= 1'b1;
    end else begin
      // The output is released as soon as chip select is seen high.
      if (csn) begin
        so_oe_n <= 1'b1;
      end
      if (cs_fall) begin
        cnt_r <= 5'h00;
        addressed_r <= 1'b0;
        tx_r <= hi_byte;
        so_oe_n <= 1'b1;
      end
      if (sck_fall) begin
        shift_r <= {shift_r[14:0], sdi};
        if (cnt_r != 5'h1f) begin
          cnt_r <= cnt_r + 5'h01;
        end
        if (cnt_r == 5'h01) begin
          addressed_r <= ({shift_r[0], sdi} == `SCS_ADDR_CODE);
        end
        if (cnt_r == 5'h07) begin
          // Control byte complete: pick the second byte.
          tx_r <= second_nxt;
        end
      end
      if (sck_rise && cnt_r >= 5'h02 && cnt_r < `SCS_FRAME_BITS) begin
        // The first two bits are never driven, so the output stays
        // released while the address bits are still arriving.
        if (drive_ok) begin
          so_oe_n <= 1'b0;
          so_out <= so_bit;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register writes land at the end of a good frame only; a cut or long
  // frame, or one not addressed to this device, leaves both untouched.
  always @(posedge clk) begin
    if (reset || !rst_pin_n) begin
      select_r <= `SCS_SELECT_RST;
      state_r <= `SCS_SERIAL_RST;
    end else if (frame_ok) begin
      if (write_serial_state_cmd) begin
        state_r <= {shift_r[7:2], 2'h3};
      end
      if (write_select_cmd) begin
        select_r <= {shift_r[7:2], 2'h3};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Power stage control truth table.
  // Register contents only change at the end of a good frame, so the
  // stages switch to new settings there. In parallel mode the stages
  // follow the synchronised pins, a few clocks behind them.
  wire [5:0] on_nxt;
  genvar g;
  generate
    for (g = 0; g < 6; g = g + 1) begin : g_ch
      reg on_ch;
      always @* begin
        if (select_r[g+2]) begin
          // Parallel control: on when the pin matches the polarity level.
          on_ch = (par_s[g] == pol_s);
        end else begin
          // Serial control: the state bits are active low.
          on_ch = ~state_r[g+2];
        end
      end
      assign on_nxt[g] = on_ch;
    end
  endgenerate

  always @(posedge clk) begin
    if (reset || !rst_pin_n) begin
      power_output <= 6'h00;
    end else begin
      power_output <= on_nxt;
    end
  end

  // The fault pin repeats the common flag one clock later, so it still
  // shows a fault for one clock after the clearing frame has cleared it.

  always @(posedge clk) begin
    if (reset || !rst_pin_n) begin
      fault_n <= 1'b1;
    end else begin
      fault_n <= common_fault_n;
    end
  end
endmodule // scs_switch_ctrl

// ---- rtl/scs_sync.v ----
// Three-stage synchroniser; the output changes once stages two and three
// agree, so a single-cycle glitch after the first stage is filtered.
module scs_sync #(
  parameter W = 1,
  parameter [W-1:0] INIT = {W{1'b0}}
) (
  input wire clk,
  input wire reset,
  input wire [W-1:0] d,
  output reg [W-1:0] q
);
  reg [W-1:0] s1_r;
  reg [W-1:0] s2_r;
  reg [W-1:0] s3_r;
  integer i;

  always @(posedge clk) begin
    if (reset) begin
      s1_r <= INIT;
      s2_r <= INIT;
      s3_r <= INIT;
      q <= INIT;
    end else begin
      s1_r <= d;
      s2_r <= s1_r;
      s3_r <= s2_r;
      for (i = 0; i < W; i = i + 1) begin
        if (s2_r[i] == s3_r[i]) begin
          q[i] <= s3_r[i];
        end
      end
    end
  end
endmodule // scs_sync

// ---- tb/scs_spi_master.sv ----
module scs_spi_master (
  output logic cs_n = 1'b1,
  output logic sclk = 1'b0,
  output logic si = 1'b0,
  input logic so_line
);
  timeunit 1ns;
  timeprecision 100ps;
  // Sclk stays low while chip select moves; si is flipped after a frame so
  // a stale bit never looks held.
  task automatic xfer(input logic [15:0] tx, input int n,
                      output logic [15:0] rx);
    #1.3 cs_n = 1'b0;
    #62.5;
    for (int i = 0; i < n; i++) begin
      sclk = 1'b1;
      si = tx[15];
      tx = tx << 1;
      #62.5;
      rx = {rx[14:0], so_line};
      sclk = 1'b0;
      #62.5;
    end
    cs_n = 1'b1;
    si = ~si;
    #125;
  endtask
endmodule // scs_spi_master

// ---- tb/scs_switch_ctrl_bench.sv ----
`include "scs_defs.vh"
module scs_switch_ctrl_bench;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [7:0] CLEAN = 8'bzz11_1111;
  logic clk = 1'b0, reset = 1'b1, reset_n_pin = 1'b1, pol = 1'b0;
  logic [5:0] pins = 6'h00, ovl = 6'h00, opn = 6'h00, sgnd = 6'h00;
  logic [5:0] ot = 6'h00, power_output;
  logic cs_n, sclk, si, so_out, so_oe_n, fault_n;
  logic [15:0] rx;
  int n_fail = 0, num_checks = 0, cycles = 0;
  wire so_line = so_oe_n ? 1'bz : so_out;
  always #2 clk = ~clk;
  scs_switch_ctrl i_dut (.clk, .reset, .reset_n_pin, .cs_n, .sclk, .si,
    .so_out, .so_oe_n, .parallel_input_pin(pins), .input_polarity_pin(pol),
    .ch_overload(ovl), .ch_open_load(opn), .ch_short_gnd(sgnd),
    .ch_overtemp(ot), .power_output, .fault_n);
  scs_spi_master i_mst (.cs_n, .sclk, .si, .so_line);
  ////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    $display("checks %0d failures %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("FAIL %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cmd(input logic [5:0] c, input logic [7:0] d, int n = 16);
    i_mst.xfer({c, 2'b11, d}, n, rx);
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      n_fail++;
      stop_test();
    end
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic t_serial();
    cmd(`SCS_CMD_RD_SELECT, 8'h00);
    check(rx, {CLEAN, 8'hff});
    check({10'h0, power_output}, 16'h003f);
    cmd(`SCS_CMD_WR_SELECT, 8'h00);
    check(rx, {CLEAN, 8'hff});
    cmd(`SCS_CMD_WR_STATE, 8'h5c);
    check({10'h0, power_output}, 16'h0028);
    cmd(`SCS_CMD_RD_STATE, 8'h00);
    check(rx, {CLEAN, 8'h5f});
  endtask
  task automatic t_refused();
    cmd(`SCS_CMD_WR_STATE, 8'h00, 15);
    cmd(`SCS_CMD_WR_STATE, 8'h00, 17);
    cmd(6'h21, 8'h00);
    check(rx, {CLEAN, 8'hff});
    i_mst.xfer(16'h5800, 16, rx);
    check(rx, 16'hzzzz);
    check({10'h0, power_output}, 16'h0028);
  endtask
  task automatic t_pin_reset();
    @(negedge clk);
    reset_n_pin = 1'b0;
    repeat (8) @(negedge clk);
    check({10'h0, power_output}, 16'h0000);
    reset_n_pin = 1'b1;
    repeat (8) @(negedge clk);
    cmd(`SCS_CMD_RD_SELECT, 8'h00);
    check(rx, {CLEAN, 8'hff});
  endtask
  task automatic t_parallel();
    for (int p = 0; p < 2; p++) begin
      @(negedge clk);
      pins = 6'h0f;
      pol = p[0];
      repeat (10) @(negedge clk);
      check({10'h0, power_output}, p ? 16'h000f : 16'h0030);
    end
  endtask
  task automatic t_faults();
    @(negedge clk);
    {sgnd, opn, ovl, ot} = {6'h01, 6'h02, 6'h08, 6'h20};
    repeat (10) @(negedge clk);
    {sgnd, opn, ovl, ot} = 24'h0;
    repeat (10) @(negedge clk);
    check({15'h0, fault_n}, 16'h0000);
    cmd(`SCS_CMD_READ_DIAGNOSIS_CMD, 8'h00, 15);
    cmd(`SCS_CMD_READ_DIAGNOSIS_CMD, 8'h00);
    check(rx, {8'bzz00_1011, 8'hb4});
    cmd(`SCS_CMD_READ_DIAGNOSIS_CMD, 8'h00);
    check(rx, {CLEAN, 8'hff});
    check({15'h0, fault_n}, 16'h0001);
  endtask
  initial begin
    repeat (6) @(negedge clk);
    reset = 1'b0;
    repeat (8) @(negedge clk);
    t_serial();
    t_refused();
    t_pin_reset();
    t_parallel();
    t_faults();
    stop_test();
  end
endmodule // scs_switch_ctrl_bench

// ---- tb/scs_switch_ctrl_checker.sv ----
module scs_switch_ctrl_checker (
  input logic clk,
  input logic reset,
  input logic reset_n_pin,
  input logic cs_n,
  input logic [5:0] parallel_input_pin,
  input logic input_polarity_pin,
  input logic [5:0] ch_short_gnd,
  input logic [5:0] ch_overtemp,
  input logic so_oe_n,
  input logic [5:0] power_output,
  input logic fault_n
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // Run lengths leave room for the input synchronisers.
  chk_pin_off: assert property (
    !reset_n_pin [*6] |-> power_output == 6'h00) else $error("on in reset");
  chk_pin_hiz: assert property (
    !reset_n_pin [*6] |-> so_oe_n) else $error("so driven in reset");
  chk_short_fault: assert property (
    (ch_short_gnd != 6'h00) [*7] |-> !fault_n) else $error("no fault");
  chk_temp_fault: assert property (
    (ch_overtemp != 6'h00) [*7] |-> !fault_n) else $error("no overtemp");
  chk_fault_held: assert property (
    ((!cs_n && reset_n_pin) [*8]) ##0 !fault_n |=> !fault_n)
    else $error("fault lost");
  chk_out_hold: assert property (
    (!cs_n && reset_n_pin && $stable(parallel_input_pin) &&
    $stable(input_polarity_pin)) [*8] |=> $stable(power_output))
    else $error("output moved in frame");
  chk_idle_hiz: assert property (
    cs_n [*8] |-> so_oe_n) else $error("so driven while idle");
  chk_drive_frame: assert property (
    $fell(so_oe_n) |-> !cs_n) else $error("so driven off frame");
endmodule // scs_switch_ctrl_checker

bind scs_switch_ctrl scs_switch_ctrl_checker i_chk (.clk, .reset,
  .reset_n_pin, .cs_n, .parallel_input_pin, .input_polarity_pin,
  .ch_short_gnd, .ch_overtemp, .so_oe_n, .power_output, .fault_n);
